// file: axis_flag.sv
`timescale 1ns/1ns
module axis_flag
    import status_alias_pkg::*;
(
    input  wire logic i_sys_clk, // System clock
    input  wire logic i_rst,     // Async reset, active high
    input  wire logic i_acq,     // New acquisition done, pulse
    input  wire logic i_rd_msb,  // High output byte read, pulse
    output logic      o_rdy,     // Data ready flag
    output logic      o_ovw      // Overwrite flag
);

    // Set wins over clear so an acquisition during the read is not lost
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdy <= 1'b0;
        else if (i_acq)
            o_rdy <= 1'b1;
        else if (i_rd_msb)
            o_rdy <= 1'b0;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_ovw <= 1'b0;
        else if (i_acq && o_rdy && !i_rd_msb)
            o_ovw <= 1'b1;
        else if (i_rd_msb)
            o_ovw <= 1'b0;
    end

endmodule

// file: host_model.sv
`timescale 1ns/1ns
module host_model
    import status_alias_pkg::*;
(
    input  wire logic  i_sys_clk,   // System clock
    output logic       o_rd_strobe, // Register read, pulse
    output logic [7:0] o_rd_addr,   // Register read address
    output axis_type   o_rd_msb     // High byte reads, pulses
);
    initial
    begin
        o_rd_strobe = 1'b0;
        o_rd_addr   = 8'h5a;
        o_rd_msb    = '0;
    end

    // Address is inverted once the strobe drops so a stale value never helps
    task automatic read_reg(input logic [7:0] addr);
        o_rd_strobe = 1'b1;
        o_rd_addr   = addr;
        @(posedge i_sys_clk);
        #1;
        o_rd_strobe = 1'b0;
        o_rd_addr   = ~addr;
        // Idle edge so a back-to-back call never retoggles the strobe in one step
        @(posedge i_sys_clk);
        #1;
    endtask

    task automatic read_msb(input axis_type axes);
        o_rd_msb = axes;
        @(posedge i_sys_clk);
        #1;
        o_rd_msb = '0;
        @(posedge i_sys_clk);
        #1;
    endtask
endmodule

// file: status_alias.sv
`timescale 1ns/1ns
// Behaviour
// - Mode zero shows ready view, else FIFO
// - Status sits at address zero
// - Combined overwrite set on overrun, cleared all-read
// - Axis overwrite set on overrun, cleared MSB read
// - Combined ready set any axis, cleared all-read
// - Axis ready set on acquisition, cleared MSB read
// - Ready view bit order overwrite then ready
// - FIFO view overflow, watermark, six-bit count
// - Overflow flag follows overflow condition
// - Watermark flag while count at or above mark
// - Trigger mode watermark reports trigger event
// - FIFO view read clears FIFO source bit
// - Count zero empty, up to 32 samples
// - All flags and count zero after reset
// - Pointer to zero on I2C stop only
// - FIFO source set on overflow or watermark
module status_alias
    import status_alias_pkg::*;
(
    input  wire logic       i_sys_clk,     // System clock, 100 MHz
    input  wire logic       i_rst,         // Async reset, active high
    input  wire logic [1:0] i_fifo_mode,   // FIFO operating mode
    input  wire logic [5:0] i_wmrk,        // Programmed watermark
    input  wire logic [5:0] i_fifo_cnt,    // Stored sample count
    input  wire logic       i_fifo_ovf,    // FIFO overflowed level
    input  wire logic       i_fifo_trig,   // Trigger event detected level
    input  wire logic       i_fifo_push,   // Sample entered FIFO, pulse
    input  wire axis_type   i_acq,         // Per-axis acquisition done, pulses
    input  wire axis_type   i_rd_msb,      // Per-axis high byte read, pulses
    input  wire logic       i_rd_strobe,   // Register read strobe, pulse
    input  wire logic [7:0] i_rd_addr,     // Register read address
    input  wire logic       i_i2c_mode,    // Interface is I2C
    input  wire logic       i_i2c_stop,    // I2C stop detected, pulse
    input  wire logic       i_ptr_load,    // Load pointer, pulse
    input  wire logic [7:0] i_ptr_val,     // Pointer load value
    input  wire logic       i_ptr_inc,     // Auto-increment pointer, pulse
    output logic [7:0]      o_status,      // Status register value
    output logic [7:0]      o_ptr,         // Auto-increment pointer
    output logic            o_src_fifo     // FIFO interrupt source bit
);

    axis_type       axis_rdy;
    axis_type       axis_ovw;
    axis_type       seen_msb;
    logic           all_rdy;
    logic           all_ovw;
    ready_view_type ready_view;
    fifo_view_type  fifo_view;
    logic [7:0]     next_status;
    logic           wmrk_hit;
    logic           wmrk_prev;
    logic           ovf_prev;
    logic           fifo_rd;
    logic           src_pending;
    logic           all_read;

    function automatic logic mark_reached(input logic [5:0] cnt, input logic [5:0] mark);
        mark_reached = (cnt >= mark);
    endfunction

    genvar g;
    generate
        for (g = 0; g < AXIS_COUNT; g++)
        begin : g_axis
            axis_flag u_flag
            (
                .i_sys_clk (i_sys_clk),
                .i_rst     (i_rst),
                .i_acq     (i_acq[g]),
                .i_rd_msb  (i_rd_msb[g]),
                .o_rdy     (axis_rdy[g]),
                .o_ovw     (axis_ovw[g])
            );
        end
    endgenerate

    // Combined flags clear only once every axis MSB was read since the last set
    assign all_read = &(seen_msb | i_rd_msb);

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            seen_msb <= '0;
        else if (|i_acq || all_read)
            seen_msb <= '0;
        else
            seen_msb <= seen_msb | i_rd_msb;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            all_rdy <= 1'b0;
        else if (|i_acq)
            all_rdy <= 1'b1;
        else if (all_read)
            all_rdy <= 1'b0;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            all_ovw <= 1'b0;
        else if (|(i_acq & axis_rdy))
            all_ovw <= 1'b1;
        else if (all_read)
            all_ovw <= 1'b0;
    end

    assign wmrk_hit = (i_fifo_mode == FIFO_MODE_TRIG) ? i_fifo_trig
                    : mark_reached(i_fifo_cnt, i_wmrk);

    always_comb
    begin
        ready_view = '{all_ovw, axis_ovw, all_rdy, axis_rdy};
        fifo_view  = '{i_fifo_ovf, wmrk_hit,
                       (i_fifo_cnt > FIFO_CNT_MAX) ? FIFO_CNT_MAX : i_fifo_cnt};
        if (i_fifo_mode == FIFO_MODE_OFF)
            next_status = ready_view;
        else
            next_status = fifo_view;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_status <= STATUS_RESET;
        else
            o_status <= next_status;
    end

    assign fifo_rd = i_rd_strobe && (i_rd_addr == STATUS_ADDR)
                     && (i_fifo_mode != FIFO_MODE_OFF);

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wmrk_prev <= 1'b0;
            ovf_prev  <= 1'b0;
        end
        else
        begin
            wmrk_prev <= wmrk_hit;
            ovf_prev  <= i_fifo_ovf;
        end
    end

    // Source still active after a clear re-arms on the next pushed sample
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            src_pending <= 1'b0;
        else if (fifo_rd)
            src_pending <= 1'b1;
        else if (i_fifo_push || !(wmrk_hit || i_fifo_ovf))
            src_pending <= 1'b0;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_src_fifo <= 1'b0;
        else if ((wmrk_hit && !wmrk_prev) || (i_fifo_ovf && !ovf_prev))
            o_src_fifo <= 1'b1;
        else if (src_pending && i_fifo_push && (wmrk_hit || i_fifo_ovf))
            o_src_fifo <= 1'b1;
        else if (fifo_rd)
            o_src_fifo <= 1'b0;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_ptr <= STATUS_ADDR;
        else if (i_ptr_load)
            o_ptr <= i_ptr_val;
        else if (i_i2c_mode && i_i2c_stop)
            o_ptr <= STATUS_ADDR;
        else if (i_ptr_inc)
            o_ptr <= o_ptr + 8'h01;
    end

    property p_view_select;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_fifo_mode == FIFO_MODE_OFF) |=> (o_status == $past(ready_view));
    endproperty
    a_view_select: assert property (p_view_select)
        else $error("status view not ready view in mode zero");

    property p_fifo_view;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_fifo_mode != FIFO_MODE_OFF) |=> (o_status[7] == $past(i_fifo_ovf));
    endproperty
    a_fifo_view: assert property (p_fifo_view)
        else $error("overflow bit does not follow overflow");

    property p_wmrk;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_fifo_mode == 2'h1 && i_fifo_cnt >= i_wmrk) |=> o_status[6];
    endproperty
    a_wmrk: assert property (p_wmrk)
        else $error("watermark bit low at or above mark");

    property p_trig;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_fifo_mode == FIFO_MODE_TRIG) |=> (o_status[6] == $past(i_fifo_trig));
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger mode watermark bit mismatch");

    property p_axis_clr;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd_msb.x && !i_acq.x) |=> (!axis_rdy.x && !axis_ovw.x);
    endproperty
    a_axis_clr: assert property (p_axis_clr)
        else $error("x flags not cleared by msb read");

    property p_axis_ovw;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_acq.y && axis_rdy.y && !i_rd_msb.y) |=> axis_ovw.y ##0 all_ovw;
    endproperty
    a_axis_ovw: assert property (p_axis_ovw)
        else $error("y overwrite not set on overrun");

    property p_all_rdy;
        @(posedge i_sys_clk) disable iff (i_rst)
        (|i_acq) |=> all_rdy;
    endproperty
    a_all_rdy: assert property (p_all_rdy)
        else $error("combined ready not set");

    property p_src_clr;
        @(posedge i_sys_clk) disable iff (i_rst)
        (fifo_rd && !(wmrk_hit && !wmrk_prev) && !(i_fifo_ovf && !ovf_prev)
         && !(src_pending && i_fifo_push)) |=> !o_src_fifo;
    endproperty
    a_src_clr: assert property (p_src_clr)
        else $error("fifo source not cleared by status read");

    property p_stop;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_i2c_mode && i_i2c_stop && !i_ptr_load) |=> (o_ptr == STATUS_ADDR);
    endproperty
    a_stop: assert property (p_stop)
        else $error("pointer not reset on stop");

endmodule

// file: status_alias_pkg.sv
package status_alias_pkg;

    localparam logic [7:0] STATUS_ADDR     = 8'h00;
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [1:0] FIFO_MODE_OFF   = 2'h0;
    localparam logic [1:0] FIFO_MODE_TRIG  = 2'h3;
    localparam logic [5:0] FIFO_CNT_EMPTY  = 6'h00;
    localparam logic [5:0] FIFO_CNT_MAX    = 6'h20;
    localparam int         AXIS_COUNT      = 3;

    // Per-axis event and read-strobe bundle, bit 0 = X, 1 = Y, 2 = Z
    typedef struct packed {
        logic z;
        logic y;
        logic x;
    } axis_type;

    // Data-ready view layout, bit 7 down to bit 0
    typedef struct packed {
        logic     all_ovw;
        axis_type ovw;
        logic     all_rdy;
        axis_type rdy;
    } ready_view_type;

    // FIFO status view layout
    typedef struct packed {
        logic       ovf;
        logic       wmrk;
        logic [5:0] cnt;
    } fifo_view_type;

endpackage

// file: tb_status_alias.sv
`timescale 1ns/1ns
module tb_status_alias
    import status_alias_pkg::*;
;
    logic       i_sys_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [1:0] mode = 2'h0;
    logic [5:0] wmrk = 6'h3f;
    logic [5:0] cnt = 6'h00;
    logic       ovf = 1'b0;
    logic       trig = 1'b0;
    logic       push = 1'b0;
    axis_type   acq = '0;
    logic       stop = 1'b0;
    logic       i2c = 1'b0;
    logic       ld = 1'b0;
    logic       inc = 1'b0;
    logic [7:0] pval = 8'h05;
    logic       rd_stb;
    logic [7:0] rd_addr;
    axis_type   rd_msb;
    logic [7:0] status;
    logic [7:0] ptr;
    logic       src;
    int         miscompares = 0;
    int         compares = 0;

    host_model i_host_model (.i_sys_clk(i_sys_clk), .o_rd_strobe(rd_stb),
        .o_rd_addr(rd_addr), .o_rd_msb(rd_msb));
    status_alias i_status_alias (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_fifo_mode(mode), .i_wmrk(wmrk), .i_fifo_cnt(cnt), .i_fifo_ovf(ovf),
        .i_fifo_trig(trig), .i_fifo_push(push), .i_acq(acq), .i_rd_msb(rd_msb),
        .i_rd_strobe(rd_stb), .i_rd_addr(rd_addr), .i_i2c_mode(i2c),
        .i_i2c_stop(stop), .i_ptr_load(ld), .i_ptr_val(pval), .i_ptr_inc(inc),
        .o_status(status), .o_ptr(ptr), .o_src_fifo(src));

    initial
    begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic fire(input axis_type a);
        acq = a;
        tick(1);
        acq = '0;
        tick(1);
    endtask

    task automatic wrap_up();
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial
    begin
        tick(8);
        i_rst = 1'b0;
        chk(status, 8'h00);
        chk(ptr, 8'h00);
        chk({7'h00, src}, 8'h00);
        fire(3'b001);
        chk(status, 8'h09);
        fire(3'b001);
        chk(status, 8'h99);
        i_host_model.read_msb(3'b001);
        tick(1);
        chk(status, 8'h88);
        i_host_model.read_msb(3'b010);
        i_host_model.read_msb(3'b100);
        tick(1);
        chk(status, 8'h00);
        fire(3'b111);
        i_host_model.read_msb(3'b100);
        tick(1);
        chk(status, 8'h0b);
        mode = 2'h1;
        cnt = 6'h05;
        wmrk = 6'h05;
        ovf = 1'b1;
        tick(3);
        chk(status, 8'hc5);
        chk({7'h00, src}, 8'h01);
        i_host_model.read_reg(8'h01);
        chk({7'h00, src}, 8'h01);
        i_host_model.read_reg(STATUS_ADDR);
        chk({7'h00, src}, 8'h00);
        push = 1'b1;
        tick(1);
        push = 1'b0;
        tick(2);
        chk({7'h00, src}, 8'h01);
        cnt = 6'h04;
        tick(2);
        chk(status, 8'h84);
        mode = 2'h2;
        ovf = 1'b0;
        cnt = FIFO_CNT_MAX;
        wmrk = 6'h21;
        tick(2);
        chk(status, 8'h20);
        cnt = 6'h2c;
        tick(2);
        chk(status, 8'h60);
        mode = FIFO_MODE_TRIG;
        cnt = FIFO_CNT_EMPTY;
        wmrk = 6'h3f;
        trig = 1'b1;
        tick(2);
        chk(status, 8'h40);
        mode = FIFO_MODE_OFF;
        tick(2);
        chk(status, 8'h0b);
        i2c = 1'b1;
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        stop = 1'b1;
        tick(1);
        stop = 1'b0;
        tick(1);
        chk(ptr, 8'h00);
        i2c = 1'b0;
        pval = 8'h37;
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        stop = 1'b1;
        tick(1);
        stop = 1'b0;
        inc = 1'b1;
        tick(1);
        inc = 1'b0;
        tick(1);
        chk(ptr, 8'h38);
        // Mid-run reset with combined, X and Y ready flags, pointer and source bit set
        i_rst = 1'b1;
        tick(2);
        i_rst = 1'b0;
        chk(status, 8'h00);
        chk(ptr, 8'h00);
        chk({7'h00, src}, 8'h00);
        wrap_up();
    end
endmodule
